// *** common/vspg_pkg.sv ***
package vspg_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] VSPG_OFS_PERIOD_LOW = 8'h10;
    localparam logic [7:0] VSPG_OFS_BURST = 8'h11;
    localparam logic [7:0] VSPG_OFS_VIDEO = 8'h12;
    localparam logic [7:0] VSPG_OFS_ACTIVE_LOW = 8'h13;
    localparam logic [7:0] VSPG_OFS_HIGH = 8'h14;
    localparam logic [7:0] VSPG_OFS_VWIN = 8'h15;
    localparam logic [7:0] VSPG_OFS_SRC = 8'h16;
    // ------------------------------------------------------------
    // Field positions, masks and reset values
    // ------------------------------------------------------------
    localparam int VSPG_ACTIVE_HI_LSB = 4;
    localparam int VSPG_PERIOD_HI_LSB = 0;
    localparam int VSPG_VWIN_LINES_LSB = 2;
    localparam int VSPG_VWIN_PASS_BIT = 1;
    localparam int VSPG_VWIN_POST_BIT = 0;
    localparam int VSPG_NFD_LSB = 4;
    localparam int VSPG_SEL_LSB = 2;
    localparam int VSPG_MSYNC_BIT = 1;
    localparam int VSPG_OFFSET_BIT = 0;
    localparam logic [7:0] VSPG_MASK_HIGH = 8'h37;
    localparam logic [7:0] VSPG_MASK_VWIN = 8'h7f;
    localparam logic [7:0] VSPG_MASK_SRC = 8'h3f;
    localparam logic [7:0] VSPG_RST_REG = 8'h00;
    localparam logic [1:0] VSPG_DATA_PASS = 2'h0;
    localparam logic [1:0] VSPG_DATA_SIMPLE = 2'h1;
    localparam logic [1:0] VSPG_DATA_RAW = 2'h2;
    localparam logic [1:0] VSPG_DATA_BLANK = 2'h3;

    // Timing source codes
    typedef enum logic [1:0] {
        VSPG_SRC_EXT = 2'h0,
        VSPG_SRC_DIG = 2'h1,
        VSPG_SRC_D1 = 2'h2,
        VSPG_SRC_D2 = 2'h3
    } vspg_src_t;

    // Register read/write port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } vspg_bus_t;

    // Per-source sync pulses
    typedef struct packed {
        logic hs;
        logic vs;
    } vspg_sync_t;
endpackage

// *** hdl/vspg_gen.sv ***
`timescale 1ns/1ns
module vspg_gen
    import vspg_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire vspg_bus_t bus,
    output logic [7:0] rdata,
    input wire vspg_sync_t ext_sync,
    input wire vspg_sync_t dig_sync,
    input wire vspg_sync_t d1_sync,
    input wire vspg_sync_t d2_sync,
    input wire logic last_eq_pulse,
    input wire logic vblank_end,
    input wire logic field_detect,
    output logic burst_hold,
    output logic active_start,
    output logic active_video,
    output logic sync_period_tick,
    output logic [1:0] data_mode,
    output logic new_field,
    output logic mixed_sync_source,
    output logic line_state_offset
);
    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [7:0] period_low_reg, burst_ofs_reg, video_ofs_reg, active_low_reg;
    logic [7:0] high_reg, vwin_reg, src_reg;
    logic [7:0] rdata_next;

    // Writes keep only defined bits so reserved bits always read zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            period_low_reg <= VSPG_RST_REG;
            burst_ofs_reg <= VSPG_RST_REG;
            video_ofs_reg <= VSPG_RST_REG;
            active_low_reg <= VSPG_RST_REG;
            high_reg <= VSPG_RST_REG;
            vwin_reg <= VSPG_RST_REG;
            src_reg <= VSPG_RST_REG;
        end else if (clk_en && bus.wr) begin
            case (bus.addr)
                VSPG_OFS_PERIOD_LOW: period_low_reg <= bus.wdata;
                VSPG_OFS_BURST: burst_ofs_reg <= bus.wdata;
                VSPG_OFS_VIDEO: video_ofs_reg <= bus.wdata;
                VSPG_OFS_ACTIVE_LOW: active_low_reg <= bus.wdata;
                VSPG_OFS_HIGH: high_reg <= bus.wdata & VSPG_MASK_HIGH;
                VSPG_OFS_VWIN: vwin_reg <= bus.wdata & VSPG_MASK_VWIN;
                VSPG_OFS_SRC: src_reg <= bus.wdata & VSPG_MASK_SRC;
                default: ;
            endcase
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        case (bus.addr)
            VSPG_OFS_PERIOD_LOW: rdata_next = period_low_reg;
            VSPG_OFS_BURST: rdata_next = burst_ofs_reg;
            VSPG_OFS_VIDEO: rdata_next = video_ofs_reg;
            VSPG_OFS_ACTIVE_LOW: rdata_next = active_low_reg;
            VSPG_OFS_HIGH: rdata_next = high_reg;
            VSPG_OFS_VWIN: rdata_next = vwin_reg;
            VSPG_OFS_SRC: rdata_next = src_reg;
            default: rdata_next = VSPG_RST_REG;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata <= VSPG_RST_REG;
        end else if (clk_en && bus.rd) begin
            rdata <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // Source selection with pin synchronisers
    // ------------------------------------------------------------
    vspg_sync_t s1_ext, s2_ext, s1_dig, s2_dig, s1_d1, s2_d1, s1_d2, s2_d2;
    logic s1_eq, s2_eq, s1_vbe, s2_vbe, s1_fd, s2_fd;
    logic hs_prev_reg, vs_prev_reg, eq_prev_reg, fd_prev_reg, vbe_prev_reg;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            {s1_ext, s2_ext, s1_dig, s2_dig} <= '0;
            {s1_d1, s2_d1, s1_d2, s2_d2} <= '0;
            {s1_eq, s2_eq, s1_vbe, s2_vbe, s1_fd, s2_fd} <= '0;
        end else if (clk_en) begin
            s1_ext <= ext_sync;
            s2_ext <= s1_ext;
            s1_dig <= dig_sync;
            s2_dig <= s1_dig;
            s1_d1 <= d1_sync;
            s2_d1 <= s1_d1;
            s1_d2 <= d2_sync;
            s2_d2 <= s1_d2;
            {s1_eq, s1_vbe, s1_fd} <= {last_eq_pulse, vblank_end, field_detect};
            {s2_eq, s2_vbe, s2_fd} <= {s1_eq, s1_vbe, s1_fd};
        end
    end

    vspg_src_t src_sel;
    vspg_sync_t sel_sync;
    assign src_sel = vspg_src_t'(src_reg[VSPG_SEL_LSB +: 2]);
    // Timing source multiplexer
    assign sel_sync = (src_sel == VSPG_SRC_EXT) ? s2_ext :
                      (src_sel == VSPG_SRC_DIG) ? s2_dig :
                      (src_sel == VSPG_SRC_D1) ? s2_d1 : s2_d2;

    wire hs_rise = sel_sync.hs && !hs_prev_reg;
    wire vs_rise = sel_sync.vs && !vs_prev_reg;
    wire eq_rise = s2_eq && !eq_prev_reg;
    wire fd_rise = s2_fd && !fd_prev_reg;
    wire vbe_rise = s2_vbe && !vbe_prev_reg;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            {hs_prev_reg, vs_prev_reg, eq_prev_reg, fd_prev_reg, vbe_prev_reg} <= '0;
        end else if (clk_en) begin
            {hs_prev_reg, vs_prev_reg} <= {sel_sync.hs, sel_sync.vs};
            {eq_prev_reg, fd_prev_reg, vbe_prev_reg} <= {s2_eq, s2_fd, s2_vbe};
        end
    end

    // ------------------------------------------------------------
    // Working set, loaded at line start so multi-byte fields stay whole
    // ------------------------------------------------------------
    logic [7:0] burst_w_reg, video_w_reg;
    logic [9:0] active_w_reg;
    logic [10:0] period_w_reg;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            burst_w_reg <= '0;
            video_w_reg <= '0;
            active_w_reg <= '0;
            period_w_reg <= '0;
        end else if (clk_en && hs_rise) begin
            burst_w_reg <= burst_ofs_reg;
            video_w_reg <= video_ofs_reg;
            active_w_reg <= {high_reg[VSPG_ACTIVE_HI_LSB +: 2], active_low_reg};
            period_w_reg <= {high_reg[VSPG_PERIOD_HI_LSB +: 3], period_low_reg};
        end
    end

    // ------------------------------------------------------------
    // Line pixel counter and event strobes
    // ------------------------------------------------------------
    logic [10:0] pix_reg;
    logic [9:0] active_cnt_reg;
    logic [8:0] burst_at, video_at;
    assign burst_at = {1'b0, burst_w_reg};
    assign video_at = 9'(burst_at + {1'b0, video_w_reg});

    // Restart on each detected sync; the counter free-runs otherwise
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pix_reg <= '0;
        end else if (clk_en) begin
            pix_reg <= hs_rise ? '0 : 11'(pix_reg + 11'h001);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            burst_hold <= 1'b0;
            active_start <= 1'b0;
            active_video <= 1'b0;
            active_cnt_reg <= '0;
            sync_period_tick <= 1'b0;
        end else if (clk_en) begin
            burst_hold <= !hs_rise && pix_reg == {2'h0, burst_at};
            active_start <= !hs_rise && pix_reg == {2'h0, video_at};
            sync_period_tick <= !hs_rise && pix_reg == period_w_reg;
            if (hs_rise) begin
                active_video <= 1'b0;
            end else if (pix_reg == {2'h0, video_at} && active_w_reg != '0) begin
                active_video <= 1'b1;
                active_cnt_reg <= active_w_reg;
            end else if (active_video) begin
                active_cnt_reg <= 10'(active_cnt_reg - 10'h001);
                active_video <= active_cnt_reg != 10'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // Vertical window state machine
    // ------------------------------------------------------------
    typedef enum logic [1:0] {VW_IDLE, VW_WIN, VW_POST} vspg_vw_t;
    vspg_vw_t vw_reg;
    logic [4:0] vw_lines_reg;
    logic offset_pend_reg;
    wire [4:0] win_lines = vwin_reg[VSPG_VWIN_LINES_LSB +: 5];
    // Line offset: optionally hold the window entry one extra line
    wire line_go = hs_rise && !offset_pend_reg;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            vw_reg <= VW_IDLE;
            vw_lines_reg <= '0;
            offset_pend_reg <= 1'b0;
        end else if (clk_en) begin
            if (hs_rise) begin
                offset_pend_reg <= 1'b0;
            end
            case (vw_reg)
                VW_IDLE: if (eq_rise) begin
                    vw_reg <= (win_lines == '0) ? VW_POST : VW_WIN;
                    vw_lines_reg <= win_lines;
                    offset_pend_reg <= src_reg[VSPG_OFFSET_BIT];
                end
                VW_WIN: if (vbe_rise || vs_rise) begin
                    vw_reg <= VW_IDLE;
                end else if (line_go) begin
                    vw_lines_reg <= 5'(vw_lines_reg - 5'h01);
                    if (vw_lines_reg == 5'h01) begin
                        vw_reg <= VW_POST;
                    end
                end
                VW_POST: if (vbe_rise || vs_rise) begin
                    vw_reg <= VW_IDLE;
                end
                default: vw_reg <= VW_IDLE;
            endcase
        end
    end

    // Data path treatment per region
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            data_mode <= VSPG_DATA_PASS;
        end else if (clk_en) begin
            case (vw_reg)
                VW_WIN: data_mode <= vwin_reg[VSPG_VWIN_PASS_BIT] ?
                                     VSPG_DATA_RAW : VSPG_DATA_SIMPLE;
                VW_POST: data_mode <= vwin_reg[VSPG_VWIN_POST_BIT] ?
                                      VSPG_DATA_SIMPLE : VSPG_DATA_BLANK;
                default: data_mode <= VSPG_DATA_PASS;
            endcase
        end
    end

    // ------------------------------------------------------------
    // New-field delay and static controls
    // ------------------------------------------------------------
    logic [3:0] nf_pipe_reg;
    wire [1:0] nf_sel = src_reg[VSPG_NFD_LSB +: 2];
    wire [4:0] nf_taps = {nf_pipe_reg, fd_rise};

    // A short tap line beats a counter: overlapping detects are kept
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            nf_pipe_reg <= '0;
            new_field <= 1'b0;
            mixed_sync_source <= 1'b0;
            line_state_offset <= 1'b0;
        end else if (clk_en) begin
            nf_pipe_reg <= nf_taps[3:0];
            new_field <= nf_taps[nf_sel];
            mixed_sync_source <= src_reg[VSPG_MSYNC_BIT];
            line_state_offset <= src_reg[VSPG_OFFSET_BIT];
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_burst;
        @(posedge sys_clk) disable iff (rst)
        clk_en && !hs_rise && pix_reg == {2'h0, burst_at} |=> burst_hold;
    endproperty
    a_burst: assert property (p_burst) else $error("burst strobe missed");

    property p_restart;
        @(posedge sys_clk) disable iff (rst)
        clk_en && hs_rise |=> pix_reg == 11'h000;
    endproperty
    a_restart: assert property (p_restart) else $error("counter not restarted");

    property p_video;
        @(posedge sys_clk) disable iff (rst)
        active_start |-> pix_reg == 11'(video_at) + 11'h001 || !clk_en;
    endproperty
    a_video: assert property (p_video) else $error("video start misplaced");

    property p_winmode;
        @(posedge sys_clk) disable iff (rst)
        clk_en && vw_reg == VW_WIN && !vwin_reg[VSPG_VWIN_PASS_BIT]
            |=> data_mode == VSPG_DATA_SIMPLE;
    endproperty
    a_winmode: assert property (p_winmode) else $error("window mode wrong");

    property p_postmode;
        @(posedge sys_clk) disable iff (rst)
        clk_en && vw_reg == VW_POST && !vwin_reg[VSPG_VWIN_POST_BIT]
            |=> data_mode == VSPG_DATA_BLANK;
    endproperty
    a_postmode: assert property (p_postmode) else $error("post window not blanked");

    property p_nf0;
        @(posedge sys_clk) disable iff (rst)
        clk_en && fd_rise && nf_sel == 2'h0 |=> new_field;
    endproperty
    a_nf0: assert property (p_nf0) else $error("new field delay wrong");

    property p_src;
        @(posedge sys_clk) disable iff (rst)
        clk_en && src_sel == VSPG_SRC_D2 && s2_d2.hs && !hs_prev_reg |=> pix_reg == 11'h000;
    endproperty
    a_src: assert property (p_src) else $error("source select wrong");

    property p_latch;
        @(posedge sys_clk) disable iff (rst)
        clk_en && hs_rise |=> period_w_reg ==
            {$past(high_reg[VSPG_PERIOD_HI_LSB +: 3]), $past(period_low_reg)};
    endproperty
    a_latch: assert property (p_latch) else $error("period not latched");

    property p_win0;
        @(posedge sys_clk) disable iff (rst)
        clk_en && vw_reg == VW_IDLE && eq_rise && win_lines == 5'h00 |=> vw_reg == VW_POST;
    endproperty
    a_win0: assert property (p_win0) else $error("empty window entered");
endmodule

// *** bench/vspg_src_model.sv ***
`timescale 1ns/1ns
// ------------------------------------------------------------
// Sync source model
// ------------------------------------------------------------
module vspg_src_model
    import vspg_pkg::*;
#(
    parameter int PER_ON = 300,
    parameter int PER_OFF = 337
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [1:0] sel,
    output vspg_sync_t ext_sync,
    output vspg_sync_t dig_sync,
    output vspg_sync_t d1_sync,
    output vspg_sync_t d2_sync,
    output logic [15:0] line_cnt
);
    logic [10:0] on_cnt_reg;
    logic [10:0] off_cnt_reg;
    logic hs_on;
    logic hs_off;

    // Unselected sources run at another period, so a wrong pick shows as a wrong line length
    assign hs_on = run && (on_cnt_reg < 11'h004);
    assign hs_off = run && (off_cnt_reg < 11'h004);
    assign ext_sync = '{hs: (sel == 2'h0) ? hs_on : hs_off, vs: 1'b0};
    assign dig_sync = '{hs: (sel == 2'h1) ? hs_on : hs_off, vs: 1'b0};
    assign d1_sync = '{hs: (sel == 2'h2) ? hs_on : hs_off, vs: 1'b0};
    assign d2_sync = '{hs: (sel == 2'h3) ? hs_on : hs_off, vs: 1'b0};

    // Line counters; sync lines rest low between runs
    always_ff @(posedge sys_clk) begin
        if (rst || !run) begin
            on_cnt_reg <= 11'h000;
            off_cnt_reg <= 11'h000;
        end else begin
            on_cnt_reg <= (on_cnt_reg == 11'(PER_ON - 1)) ? 11'h000 : on_cnt_reg + 11'h001;
            off_cnt_reg <= (off_cnt_reg == 11'(PER_OFF - 1)) ? 11'h000 : off_cnt_reg + 11'h001;
        end
        if (rst) begin
            line_cnt <= 16'h0000;
        end else if (run && on_cnt_reg == 11'h000) begin
            line_cnt <= line_cnt + 16'h0001;
        end
    end
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
    import vspg_pkg::*;
    localparam int LINE = 300;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    vspg_bus_t bus = '0;
    logic last_eq_pulse = 1'b0;
    logic vblank_end = 1'b0;
    logic field_detect = 1'b0;
    logic run = 1'b0;
    logic [1:0] sel = 2'h0;
    logic [7:0] rdata;
    vspg_sync_t ext_sync, dig_sync, d1_sync, d2_sync;
    logic burst_hold, active_start, active_video, sync_period_tick, new_field;
    logic mixed_sync_source, line_state_offset;
    logic [1:0] data_mode;
    logic [15:0] line_cnt;
    int errors = 0;
    int compares = 0;
    int cyc = 0;
    int t_burst = 0;
    int t_act = 0;
    int t_fd = 0;
    bit armed = 0;
    bit have_burst = 0;
    bit rd_seen = 0;
    logic ac_prev = 1'b0;
    logic fd_prev = 1'b0;
    logic [7:0] q_rd[$];
    int q_per[$], q_vid[$], q_act[$], q_prd[$], q_nf[$];

    // ------------------------------------------------------------
    // Clock, design and sync source
    // ------------------------------------------------------------
    initial forever #10 sys_clk = ~sys_clk;

    vspg_gen DUT (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .bus(bus), .rdata(rdata),
        .ext_sync(ext_sync), .dig_sync(dig_sync), .d1_sync(d1_sync), .d2_sync(d2_sync),
        .last_eq_pulse(last_eq_pulse), .vblank_end(vblank_end), .field_detect(field_detect),
        .burst_hold(burst_hold), .active_start(active_start), .active_video(active_video),
        .sync_period_tick(sync_period_tick), .data_mode(data_mode), .new_field(new_field),
        .mixed_sync_source(mixed_sync_source), .line_state_offset(line_state_offset));

    vspg_src_model #(.PER_ON(LINE), .PER_OFF(LINE + 37)) src_model (.sys_clk(sys_clk),
        .rst(rst), .run(run), .sel(sel), .ext_sync(ext_sync), .dig_sync(dig_sync),
        .d1_sync(d1_sync), .d2_sync(d2_sync), .line_cnt(line_cnt));

    // ------------------------------------------------------------
    // Compare and driver tasks
    // ------------------------------------------------------------
    task automatic cmp_data(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_count(input int got, input int exp, input string what);
        compares++;
        if (got != exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask

    // An empty queue yields -1, so an unexpected event always mismatches
    function automatic int pop(ref int q[$]);
        return (q.size() > 0) ? q.pop_front() : -1;
    endfunction

    function automatic logic [7:0] msk(input logic [7:0] a);
        case (a)
            VSPG_OFS_HIGH: return VSPG_MASK_HIGH;
            VSPG_OFS_VWIN: return VSPG_MASK_VWIN;
            VSPG_OFS_SRC: return VSPG_MASK_SRC;
            default: return 8'hff;
        endcase
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        bus <= '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        q_rd.push_back(e);
        @(posedge sys_clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge sys_clk);
        bus <= '0;
    endtask

    // Pulse one of the vertical or field inputs long enough to pass the synchronisers
    task automatic pulse_in(input int k);
        @(posedge sys_clk);
        case (k)
            0: last_eq_pulse <= 1'b1;
            1: vblank_end <= 1'b1;
            default: field_detect <= 1'b1;
        endcase
        repeat (4) @(posedge sys_clk);
        last_eq_pulse <= 1'b0;
        vblank_end <= 1'b0;
        field_detect <= 1'b0;
    endtask

    task automatic wait_lines(input int n);
        logic [15:0] t;
        t = line_cnt + 16'(n);
        for (int i = 0; i < 4000 && line_cnt != t; i++) @(posedge sys_clk);
        repeat (20) @(posedge sys_clk);
    endtask

    task automatic conclude;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Monitor: takes the oldest note off a queue as each result appears
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        cyc++;
        if (rd_seen) cmp_data(rdata, q_rd.pop_front(), "read data");
        rd_seen = bus.rd;
        if (armed && burst_hold) begin
            if (have_burst) cmp_count(cyc - t_burst, pop(q_per), "line period");
            t_burst = cyc;
            have_burst = 1;
        end
        if (armed && active_start) cmp_count(cyc - t_burst, pop(q_vid), "burst to video");
        if (armed && sync_period_tick) cmp_count(cyc - t_burst, pop(q_prd), "period");
        if (armed && active_video && !ac_prev) t_act = cyc;
        if (armed && !active_video && ac_prev) cmp_count(cyc - t_act, pop(q_act), "active");
        ac_prev = active_video;
        if (field_detect && !fd_prev) t_fd = cyc;
        fd_prev = field_detect;
        if (new_field) cmp_count(cyc - t_fd, pop(q_nf), "field delay");
    end

    // Watchdog: whole run is about 6400 cycles
    initial begin
        repeat (40000) @(posedge sys_clk);
        errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        conclude();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] v;
        int b_ofs, v_ofs, a_len, p_len;
        void'($urandom(92));
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        // Reset value, write, read back, then the unmapped offset after the map
        for (int a = 16; a <= 23; a++) begin
            v = 8'($urandom()) & msk(8'(a));
            rd(8'(a), VSPG_RST_REG);
            wr(8'(a), v);
            rd(8'(a), (a == 23) ? 8'h00 : v);
        end
        for (int k = 1; k < 3; k++) begin
            wr(VSPG_OFS_SRC, 8'(k));
            repeat (3) @(posedge sys_clk);
            cmp_data({6'h00, mixed_sync_source, line_state_offset}, 8'(k), "src bits");
        end
        $display("test registers done");
        // Each source in turn, with the other three running at a wrong period
        for (int s = 0; s < 4; s++) begin
            b_ofs = (s == 1) ? (25 + $urandom_range(8, 1)) - 25 : $urandom_range(8, 1);
            v_ofs = $urandom_range(8, 1);
            a_len = 256 + $urandom_range(7, 0);
            p_len = 256 + $urandom_range(31, 0);
            wr(VSPG_OFS_BURST, 8'(b_ofs));
            wr(VSPG_OFS_VIDEO, 8'(v_ofs));
            wr(VSPG_OFS_ACTIVE_LOW, 8'(a_len));
            wr(VSPG_OFS_PERIOD_LOW, 8'(p_len));
            wr(VSPG_OFS_HIGH, 8'h11);
            wr(VSPG_OFS_SRC, 8'(s << VSPG_SEL_LSB));
            for (int k = 0; k < 4; k++) begin
                if (k > 0) q_per.push_back(LINE);
                q_vid.push_back(v_ofs);
                q_act.push_back(a_len);
                q_prd.push_back(p_len - b_ofs);
            end
            @(negedge sys_clk);
            armed = 1;
            have_burst = 0;
            @(posedge sys_clk);
            sel <= 2'(s);
            run <= 1'b1;
            wait_lines(4);
            run <= 1'b0;
            repeat (LINE) @(posedge sys_clk);
            @(negedge sys_clk);
            armed = 0;
        end
        $display("test sources done");
        // Window without offset (simple, then blank) and with offset (raw, then simple)
        sel <= 2'h0;
        for (int c = 0; c < 2; c++) begin
            wr(VSPG_OFS_SRC, 8'(c));
            wr(VSPG_OFS_VWIN, c ? 8'h07 : 8'h08);
            @(posedge sys_clk);
            run <= 1'b1;
            wait_lines(1);
            cmp_data(8'(data_mode), 8'(VSPG_DATA_PASS), "before window");
            pulse_in(0);
            repeat (20) @(posedge sys_clk);
            cmp_data(8'(data_mode), 8'(c ? VSPG_DATA_RAW : VSPG_DATA_SIMPLE), "in");
            wait_lines(1);
            cmp_data(8'(data_mode), 8'(c ? VSPG_DATA_RAW : VSPG_DATA_SIMPLE), "in");
            wait_lines(1);
            cmp_data(8'(data_mode), 8'(c ? VSPG_DATA_SIMPLE : VSPG_DATA_BLANK), "post");
            pulse_in(1);
            repeat (10) @(posedge sys_clk);
            cmp_data(8'(data_mode), 8'(VSPG_DATA_PASS), "after blanking");
            @(posedge sys_clk);
            run <= 1'b0;
        end
        $display("test vertical window done");
        // Every field delay code; a new field shows 3 cycles plus the delay after the
        // monitor first samples its cause high (two sync stages, edge detect, output flop)
        for (int d = 0; d < 4; d++) begin
            wr(VSPG_OFS_SRC, 8'(d << VSPG_NFD_LSB));
            q_nf.push_back(d + 3);
            pulse_in(2);
            repeat (12) @(posedge sys_clk);
        end
        $display("test field delay done");
        cmp_count(q_per.size() + q_vid.size() + q_act.size() + q_prd.size() + q_nf.size(), 0,
            "missing events");
        conclude();
    end
endmodule
